// file: hdl/tmr2_defs.vh
// Constants for the 16-bit general-purpose timer block.
// Assumes inclusion by bare name from the timer design files.
`ifndef TMR2_DEFS_VH
`define TMR2_DEFS_VH
// ==========================================================
// Register word offsets (byte addresses, Avalon-MM).
`define TMR2_OFF_CTRL 8'hc8
`define TMR2_OFF_MODE 8'hc9
`define TMR2_OFF_RCL 8'hca
`define TMR2_OFF_RCH 8'hcb
`define TMR2_OFF_CNTL 8'hcc
`define TMR2_OFF_CNTH 8'hcd
`define TMR2_OFF_IRQEN 8'hd0
`define TMR2_OFF_STAT 8'hd4
`define TMR2_OFF_MASK 8'hd8
// ==========================================================
// Control register fields.
`define TMR2_CTRL_FLAG 7
`define TMR2_CTRL_RUN 2
`define TMR2_CTRL_CMP 0
// Mode register fields.
`define TMR2_MODE_RELOAD_GATE 7
`define TMR2_MODE_DIV_HI 6
`define TMR2_MODE_DIV_LO 4
`define TMR2_MODE_CAPCLR 3
`define TMR2_MODE_CMPCLR 2
`define TMR2_MODE_TRG_HI 1
`define TMR2_MODE_TRG_LO 0
// Status bits.
`define TMR2_ST_EVENT 0
`define TMR2_ST_CAP 1
// ==========================================================
// Reset values, the all-ones overflow count and the overflow trigger code.
`define TMR2_RST_BYTE 8'h00
`define TMR2_RST_WORD 16'h0000
`define TMR2_ALL_ONES 16'hffff
`define TMR2_TRG_OVF 2'h0
`endif

// file: hdl/tmr2_prescaler.v
// Prescaler that emits one-cycle count ticks at a selectable division.
// Assumes a single clock and an active-low asynchronous reset.
`timescale 1ns/10ps
`default_nettype none
`include "tmr2_defs.vh"
module tmr2_prescaler #(
   parameter WIDTH = 9
) (
   input wire clk,
   input wire arst_n,
   input wire run,
   input wire [2:0] divSel,
   output reg tick
);
   reg [WIDTH-1:0] divCnt;
   reg [WIDTH-1:0] divMask;
   // ==========================================================
   // Division table.
   always @* begin
      case (divSel)
         3'h0: divMask = 9'h000; // [RL8]
         3'h1: divMask = 9'h003; // [RL8]
         3'h2: divMask = 9'h00f; // [RL8]
         3'h3: divMask = 9'h01f; // [RL8]
         3'h4: divMask = 9'h03f; // [RL8]
         3'h5: divMask = 9'h07f; // [RL9]
         3'h6: divMask = 9'h0ff; // [RL9]
         default: divMask = 9'h1ff; // [RL9]
      endcase
   end
   // Counter freezes while halted, so a restart resumes the partial period.
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         divCnt <= 9'h000;
         tick <= 1'b0;
      end else if (run) begin
         tick <= ((divCnt & divMask) == divMask);
         divCnt <= ((divCnt & divMask) == divMask) ? 9'h000 : divCnt + 9'h001;
      end else begin
         tick <= 1'b0;
      end
   end
endmodule // tmr2_prescaler
`default_nettype wire

// file: hdl/tmr2_timer.v
// Top of the 16-bit timer with Avalon-MM register access and two interrupts.
// Assumes capture events are pins from another domain, synchronised here.
//
// Summary of operation
// RL1 - Flag sets on overflow or compare match.
// RL2 - Flag with enables requests timer interrupt.
// RL3 - Only software clears the event flag.
// RL4 - Run bit one counts, zero stops.
// RL5 - Halting keeps the count unchanged; here a capture reload or capture clear still moves it while halted.
// RL6 - Mode bit: zero reload, one compare.
// RL7 - Reload gate enables copying reload value.
// RL8 - Prescale codes 0-4 divide 1..64.
// RL9 - Prescale codes 5-7 divide 128..512.
// RL10 - Trigger field picks overflow or capture.
// RL11 - Clear-on-match zeroes count after match.
// RL12 - Reload/compare pair is compare or reload.
//
// Added by the designer: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "tmr2_defs.vh"
module tmr2_timer (
   input wire clk,
   input wire arst_n,
   input wire [7:0] address,
   input wire read,
   input wire write,
   input wire [31:0] writedata,
   output reg [31:0] readdata,
   output reg waitrequest,
   input wire [2:0] capturePin,
   input wire globalIrqEnable,
   output reg timerIrq,
   output reg irq
);
   reg eventFlag;
   reg runBit;
   reg cmpMode;
   reg [7:0] modeReg;
   reg [15:0] reloadValue;
   reg [15:0] count;
   reg timerIrqEnable;
   reg [1:0] status;
   reg [1:0] mask;
   reg busDone;
   reg [2:0] capS1;
   reg [2:0] capS2;
   reg [2:0] capS3;
   reg [2:0] capLevel;
   wire tick;
   wire [2:0] capEvent;
   wire accept;
   wire wrCtrl;
   wire wrMode;
   wire wrRcl;
   wire wrRch;
   wire wrCntl;
   wire wrCnth;
   wire overflow;
   wire match;
   wire reloadTrig;
   wire capTrig;
   wire hwEvent;
   wire [1:0] trig;
   reg [15:0] next_count;
   reg [31:0] next_readdata;

   function [7:0] byteOf;
      input [31:0] d;
      begin
         byteOf = d[7:0];
      end
   endfunction

   // ==========================================================
   // Avalon-MM slave: one wait cycle, then the answer.
   assign accept = (read | write) & busDone;
   assign wrCtrl = accept & write & (address == `TMR2_OFF_CTRL);
   assign wrMode = accept & write & (address == `TMR2_OFF_MODE);
   assign wrRcl = accept & write & (address == `TMR2_OFF_RCL);
   assign wrRch = accept & write & (address == `TMR2_OFF_RCH);
   assign wrCntl = accept & write & (address == `TMR2_OFF_CNTL);
   assign wrCnth = accept & write & (address == `TMR2_OFF_CNTH);

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         busDone <= 1'b0;
         waitrequest <= 1'b1;
      end else begin
         busDone <= (read | write) & ~busDone;
         waitrequest <= ~((read | write) & ~busDone);
      end
   end

   always @* begin
      next_readdata = 32'h00000000;
      case (address)
         `TMR2_OFF_CTRL: begin
            next_readdata[`TMR2_CTRL_FLAG] = eventFlag;
            next_readdata[`TMR2_CTRL_RUN] = runBit;
            next_readdata[`TMR2_CTRL_CMP] = cmpMode;
         end
         `TMR2_OFF_MODE: next_readdata[7:0] = modeReg;
         `TMR2_OFF_RCL: next_readdata[7:0] = reloadValue[7:0];
         `TMR2_OFF_RCH: next_readdata[7:0] = reloadValue[15:8];
         `TMR2_OFF_CNTL: next_readdata[7:0] = count[7:0];
         `TMR2_OFF_CNTH: next_readdata[7:0] = count[15:8];
         `TMR2_OFF_IRQEN: next_readdata[0] = timerIrqEnable;
         `TMR2_OFF_STAT: next_readdata[1:0] = status;
         `TMR2_OFF_MASK: next_readdata[1:0] = mask;
         default: next_readdata = 32'h00000000;
      endcase
   end

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         readdata <= 32'h00000000;
      end else if ((read | write) & ~busDone) begin
         readdata <= next_readdata;
      end
   end

   // ==========================================================
   // Capture pins: three stages; a level is taken only once stages two and three agree.
   // This filters a single-cycle glitch at the cost of one more cycle of latency.
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         capS1 <= 3'h0;
         capS2 <= 3'h0;
         capS3 <= 3'h0;
         capLevel <= 3'h0;
      end else begin
         capS1 <= capturePin;
         capS2 <= capS1;
         capS3 <= capS2;
         capLevel <= (capS2 & capS3) | (capLevel & (capS2 | capS3));
      end
   end
   assign capEvent = capS2 & capS3 & ~capLevel;

   // ==========================================================
   // Control and mode registers.
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         runBit <= 1'b0;
         cmpMode <= 1'b0;
         modeReg <= `TMR2_RST_BYTE;
         reloadValue <= `TMR2_RST_WORD;
         timerIrqEnable <= 1'b0;
         mask <= 2'h0;
      end else begin
         if (wrCtrl) begin
            runBit <= writedata[`TMR2_CTRL_RUN];
            cmpMode <= writedata[`TMR2_CTRL_CMP];
         end
         if (wrMode) modeReg <= byteOf(writedata);
         if (wrRcl) reloadValue[7:0] <= byteOf(writedata);
         if (wrRch) reloadValue[15:8] <= byteOf(writedata);
         if (accept & write & (address == `TMR2_OFF_IRQEN)) timerIrqEnable <= writedata[0];
         if (accept & write & (address == `TMR2_OFF_MASK)) mask <= writedata[1:0];
      end
   end

   tmr2_prescaler #(
      .WIDTH(9)
   ) u_prescaler (
      .clk(clk),
      .arst_n(arst_n),
      .run(runBit), // [RL4]
      .divSel(modeReg[`TMR2_MODE_DIV_HI:`TMR2_MODE_DIV_LO]),
      .tick(tick)
   );

   // ==========================================================
   // Counter.
   assign trig = modeReg[`TMR2_MODE_TRG_HI:`TMR2_MODE_TRG_LO];
   assign overflow = runBit & tick & (count == `TMR2_ALL_ONES);
   assign match = runBit & tick & cmpMode & (count == reloadValue); // [RL6] [RL12]
   assign capTrig = ~cmpMode & (trig != `TMR2_TRG_OVF) & capEvent[trig - 2'h1]; // [RL10]
   assign reloadTrig = ~cmpMode & modeReg[`TMR2_MODE_RELOAD_GATE]
      & ((trig == `TMR2_TRG_OVF) ? overflow : capTrig); // [RL7] [RL10]
   assign hwEvent = overflow | match; // [RL1]

   always @* begin
      next_count = count;
      if (runBit & tick) begin
         next_count = count + 16'h0001; // [RL4]
      end
      if (match & modeReg[`TMR2_MODE_CMPCLR]) begin
         next_count = `TMR2_RST_WORD; // [RL11]
      end
      // Capture auto-clear wins over a reload from the same capture.
      if (reloadTrig) begin
         next_count = reloadValue; // [RL7] [RL12]
      end
      if (capTrig & modeReg[`TMR2_MODE_CAPCLR]) begin
         next_count = `TMR2_RST_WORD;
      end
      if (wrCntl) next_count[7:0] = byteOf(writedata);
      if (wrCnth) next_count[15:8] = byteOf(writedata);
   end

   // When halted only a capture reload or capture clear, or a count register write, moves the count.
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         count <= `TMR2_RST_WORD;
      end else begin
         count <= next_count; // [RL5]
      end
   end

   // ==========================================================
   // Event flag and interrupt status; hardware set wins over any clear.
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         eventFlag <= 1'b0;
         status <= 2'h0;
         timerIrq <= 1'b0;
         irq <= 1'b0;
      end else begin
         if (hwEvent) begin
            eventFlag <= 1'b1; // [RL1]
         end else if (wrCtrl) begin
            eventFlag <= writedata[`TMR2_CTRL_FLAG]; // [RL3]
         end
         status[`TMR2_ST_EVENT] <= hwEvent
            | (status[`TMR2_ST_EVENT] & ~(accept & write & (address == `TMR2_OFF_STAT)
            & writedata[`TMR2_ST_EVENT]));
         status[`TMR2_ST_CAP] <= (|capEvent)
            | (status[`TMR2_ST_CAP] & ~(accept & write & (address == `TMR2_OFF_STAT)
            & writedata[`TMR2_ST_CAP]));
         timerIrq <= eventFlag & timerIrqEnable & globalIrqEnable; // [RL2]
         irq <= |(status & mask);
      end
   end
endmodule // tmr2_timer
`default_nettype wire

// file: tb/tmr2_timer_props.sv
// Checker for the timer's bus handshake and its two interrupt outputs.
// It is bound to the timer top and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none
// ====================
// Properties.
module tmr2_checker (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [7:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [31:0] readdata,
   input wire logic waitrequest,
   input wire logic [2:0] capturePin,
   input wire logic globalIrqEnable,
   input wire logic timerIrq,
   input wire logic irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   wait_one_a: assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("request left unanswered");
   wait_short_a: assert property (!waitrequest |=> waitrequest)
      else $error("answer held too long");
   wait_idle_a: assert property (waitrequest && !read && !write |=> waitrequest)
      else $error("answer without request");
   upper_zero_a: assert property (read && !waitrequest |-> readdata[31:8] == 24'h0)
      else $error("upper read bits set");
   hole_zero_a: assert property (read && !waitrequest && !(address inside {8'hc8, 8'hc9,
      8'hca, 8'hcb, 8'hcc, 8'hcd, 8'hd0, 8'hd4, 8'hd8}) |-> readdata == 32'h0)
      else $error("unmapped read not zero");
   gie_gate_a: assert property (!globalIrqEnable |=> !timerIrq)
      else $error("timer interrupt without global enable");
   // The flag only falls through a register write, so a quiet bus keeps the request up.
   flag_keep_a: assert property (timerIrq && globalIrqEnable && !write && !$past(write)
      |=> timerIrq) else $error("timer interrupt dropped without a write");
   irq_keep_a: assert property (irq && !write && !$past(write) |=> irq)
      else $error("status interrupt dropped without a write");
endmodule // tmr2_checker
bind tmr2_timer tmr2_checker chk_u (.clk(clk), .arst_n(arst_n), .address(address),
   .read(read), .write(write), .writedata(writedata), .readdata(readdata),
   .waitrequest(waitrequest), .capturePin(capturePin), .globalIrqEnable(globalIrqEnable),
   .timerIrq(timerIrq), .irq(irq));
`default_nettype wire

// file: tb/tmr2_timer_test.sv
// Self-checking bench for the timer: registers, prescaler, flag and interrupts.
// Assumes the timer top with its Avalon-MM slave and a 50 ns clock.
`timescale 1ns/10ps
`default_nettype none
// ====================
// Bench top.
module tmr2_timer_test;
   logic clk = 1'b0, arst_n = 1'b0, read = 1'b0, write = 1'b0, globalIrqEnable = 1'b1;
   logic waitrequest, timerIrq, irq;
   logic [1:0] ti;
   logic [7:0] address = 8'h0;
   logic [2:0] capturePin = 3'h0;
   logic [31:0] writedata = 32'h0, readdata, rd, fl;
   logic [15:0] c0, c1;
   logic [7:0] regs [10] = '{8'hc8, 8'hc9, 8'hca, 8'hcb, 8'hcc, 8'hcd, 8'hd0, 8'hd4,
      8'hd8, 8'hc7};
   int divs [8] = '{1, 4, 16, 32, 64, 128, 256, 512};
   integer fail_count = 0, compares = 0, seed = 32'h0bbffc35, i, d, e;
   always #25 clk = ~clk;
   tmr2_timer dut_u (.clk(clk), .arst_n(arst_n), .address(address), .read(read),
      .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
      .capturePin(capturePin), .globalIrqEnable(globalIrqEnable), .timerIrq(timerIrq),
      .irq(irq));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic close_out;
      if (fail_count == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] dat);
      @(posedge clk);
      address <= a;
      writedata <= {24'h0, dat};
      read <= !w;
      write <= w;
      do @(posedge clk); while (waitrequest !== 1'b0);
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask
   task automatic cnt(output logic [15:0] c);
      acc(1'b0, 8'hcc, 8'h0);
      c[7:0] = rd[7:0];
      acc(1'b0, 8'hcd, 8'h0);
      c[15:8] = rd[7:0];
   endtask
   // Loads the count, runs for n cycles, samples flag and interrupts, then halts.
   task automatic go(input logic [7:0] md, ctl, input logic [15:0] c, input integer n);
      acc(1'b1, 8'hcc, c[7:0]);
      acc(1'b1, 8'hcd, c[15:8]);
      acc(1'b1, 8'hc9, md);
      acc(1'b1, 8'hc8, ctl);
      repeat (n) @(posedge clk);
      ti = {timerIrq, irq};
      acc(1'b0, 8'hc8, 8'h0);
      fl = rd;
      acc(1'b1, 8'hc8, 8'h0);
      cnt(c0);
   endtask
   initial begin
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      for (i = 0; i < 10; i++) begin
         acc(1'b0, regs[i], 8'h0);
         check(rd, 32'h0);
      end
      for (i = 1; i < 10; i++) begin
         d = $random(seed);
         if (i < 5 || i == 9) begin
            acc(1'b1, regs[i], d[7:0]);
            acc(1'b0, regs[i], 8'h0);
            check(rd, (i == 9) ? 32'h0 : {24'h0, d[7:0]});
         end
      end
      // Halting between codes leaves a prescaler remainder, hence one tick of slack.
      for (i = 0; i < 8; i++) begin
         d = divs[i];
         e = (8 * d + 6) / d;
         go({1'b0, i[2:0], 4'h0}, 8'h04, 16'h0, 8 * d);
         check({31'h0, c0 >= e - 1 && c0 <= e + 1}, 32'h1);
      end
      repeat (30) @(posedge clk);
      cnt(c1);
      check(c1, c0);
      acc(1'b1, 8'hd0, 8'h01);
      acc(1'b1, 8'hd8, 8'h01);
      acc(1'b1, 8'hca, 8'h34);
      acc(1'b1, 8'hcb, 8'h12);
      go(8'h80, 8'h04, 16'hfff0, 40);
      check(fl, 32'h84);
      check(ti, 2'b11);
      check(c0[15:8], 8'h12);
      acc(1'b0, 8'hd4, 8'h0);
      check(rd, 32'h1);
      acc(1'b1, 8'hd4, 8'h01);
      repeat (2) @(posedge clk);
      check({timerIrq, irq}, 2'b00);
      globalIrqEnable <= 1'b0;
      go(8'h00, 8'h04, 16'hfff0, 40);
      check(ti, 2'b01);
      check(c0[15:8], 8'h00);
      globalIrqEnable <= 1'b1;
      acc(1'b1, 8'hca, 8'h10);
      acc(1'b1, 8'hcb, 8'h00);
      go(8'h04, 8'h05, 16'h0, 30);
      check(fl, 32'h85);
      check({31'h0, c0 < 16'h10}, 32'h1);
      acc(1'b1, 8'hca, 8'h00);
      acc(1'b1, 8'hcb, 8'h40);
      acc(1'b1, 8'hc9, 8'h81);
      capturePin <= 3'h1;
      repeat (6) @(posedge clk);
      capturePin <= 3'h0;
      cnt(c1);
      check(c1, 16'h4000);
      acc(1'b0, 8'hd4, 8'h0);
      check(rd[1], 1'b1);
      close_out;
   end
   initial begin
      repeat (30000) @(posedge clk);
      fail_count++;
      close_out;
   end
endmodule // tmr2_timer_test
`default_nettype wire
